// *** core/pdu_pkg.sv ***
// Package with the register map, field layout, carriers and states of the peripheral DMA unit.
package pdu_pkg;

	// ****************************************************************
	// Register map (byte offsets within the served peripheral's space)
	// ****************************************************************
	localparam int REG_ADDR_W = 12;
	localparam logic [11:0] OFS_RECV_CURRENT_POINTER = 12'h100;
	localparam logic [11:0] OFS_RECV_CURRENT_COUNT = 12'h104;
	localparam logic [11:0] OFS_XMIT_CURRENT_POINTER = 12'h108;
	localparam logic [11:0] OFS_XMIT_CURRENT_COUNT = 12'h10c;
	localparam logic [11:0] OFS_RECV_NEXT_POINTER = 12'h110;
	localparam logic [11:0] OFS_RECV_NEXT_COUNT = 12'h114;
	localparam logic [11:0] OFS_XMIT_NEXT_POINTER = 12'h118;
	localparam logic [11:0] OFS_XMIT_NEXT_COUNT = 12'h11c;
	localparam logic [11:0] OFS_TRANSFER_CONTROL = 12'h120;
	localparam logic [11:0] OFS_TRANSFER_STATE = 12'h124;

	// ****************************************************************
	// Field positions and reset values
	// ****************************************************************
	localparam int BIT_RECV_REQUEST_ON = 0;
	localparam int BIT_RECV_REQUEST_OFF = 1;
	localparam int BIT_XMIT_REQUEST_ON = 8;
	localparam int BIT_XMIT_REQUEST_OFF = 9;
	localparam int COUNT_W = 16;
	localparam logic [31:0] ADDR_RESET = 32'h0000_0000;
	localparam logic [15:0] COUNT_ZERO = 16'h0000;
	localparam logic [15:0] COUNT_ONE = 16'h0001;

	// ****************************************************************
	// Item sizes and pointer steps
	// ****************************************************************
	localparam logic [1:0] SIZE_BYTE = 2'b00;
	localparam logic [1:0] SIZE_HALF = 2'b01;
	localparam logic [31:0] STEP_BYTE = 32'h0000_0001;
	localparam logic [31:0] STEP_HALF = 32'h0000_0002;
	localparam logic [31:0] STEP_WORD = 32'h0000_0004;

	// Register port command from the peripheral's own bus decode.
	typedef struct packed {
		logic rd;
		logic wr;
		logic [11:0] addr;
		logic [31:0] wdata;
	} pdu_reg_cmd_t;

	// Request held toward the system memory bus.
	typedef struct packed {
		logic write;
		logic [1:0] size;
		logic [31:0] addr;
		logic [31:0] wdata;
	} pdu_mem_req_t;

	// State of one channel: current and following buffer.
	typedef struct packed {
		logic [31:0] addr;
		logic [15:0] items;
		logic [31:0] faddr;
		logic [15:0] fitems;
	} pdu_chan_t;

	// Transfer sequencer states.
	typedef enum logic [1:0] {
		PDU_IDLE = 2'b00,
		PDU_RECV = 2'b01,
		PDU_XMIT = 2'b10
	} pdu_state_t;

endpackage

// *** core/pdu_channel.sv ***
// Register file and transfer sequencer of one peripheral DMA channel pair.
`timescale 1ns/1ns

// Behaviour
// - Ten registers at fixed offsets 0x100 to 0x124.
// - Receive count zero stops, nonzero allows transfers.
// - Transmit count zero stops, nonzero allows transfers.
// - Separate readable writable following receive pointer, count.
// - Separate readable writable following transmit pointer, count.
// - Half duplex: receive and transmit registers alias.
// - Control bit 0 enables receive unless bit 1, or in half duplex bit 9.
// - Control bit 1 disables receive requests.
// - Control bit 8 enables transmit requests.
// - Control bit 9 disables transmit requests.
// - Half duplex: receive enable clears transmit enable.
// - Half duplex: transmit enable only without receive enable.
// - Half duplex: any disable clears both directions.
// - State register shows enables in bits 0, 8.
// - Empty current count reloads from nonzero following pair.
// - Pointer advances 1, 2 or 4 per item.
// - Done flag at zero, full/empty when both zero.
module pdu_channel
	import pdu_pkg::*;
#(
	parameter bit HALF_DUPLEX = 1'b0
)
(
	// Clock and reset.
	input wire logic ref_clk_i,
	input wire logic rst_i,
	// Register port from the peripheral's bus decode.
	input wire pdu_reg_cmd_t reg_i,
	output logic [31:0] reg_rdata_o,
	// Peripheral side: ready strobes, holding registers and item size.
	input wire logic recv_ready_i,
	input wire logic [31:0] recv_holding_reg_i,
	output logic recv_taken_o,
	input wire logic xmit_ready_i,
	output logic [31:0] xmit_holding_reg_o,
	output logic xmit_load_o,
	input wire logic [1:0] item_size_i,
	// Status flags toward the peripheral status register.
	output logic recv_block_done_o,
	output logic recv_all_full_o,
	output logic xmit_block_done_o,
	output logic xmit_all_empty_o,
	// System memory bus master port.
	output logic mem_req_o,
	output pdu_mem_req_t mem_o,
	input wire logic mem_ack_i,
	input wire logic [31:0] mem_rdata_i
);

	// ****************************************************************
	// Declarations
	// ****************************************************************
	// Index of the transmit channel state; half duplex shares entry 0.
	localparam int XI = HALF_DUPLEX ? 0 : 1;

	pdu_chan_t ch_reg [0:1]; // Channel state, entry 0 is receive.
	pdu_chan_t ch_next [0:1]; // Next channel state.
	logic recv_on_reg; // Receive requests enabled.
	logic recv_on_next; // Next receive enable.
	logic xmit_on_reg; // Transmit requests enabled.
	logic xmit_on_next; // Next transmit enable.
	pdu_state_t state_reg; // Sequencer state.
	pdu_state_t state_next; // Next sequencer state.
	pdu_mem_req_t mem_reg; // Held memory request.
	pdu_mem_req_t mem_next; // Next memory request.
	logic [31:0] rdata_reg; // Read data register.
	logic [31:0] rdata_next; // Next read data.
	logic [31:0] xdata_reg; // Data for the transmit holding register.
	logic [31:0] xdata_next; // Next transmit data.
	logic taken_reg; // Pulse: receive holding register read.
	logic taken_next; // Next receive pulse.
	logic load_reg; // Pulse: transmit holding register loaded.
	logic load_next; // Next transmit pulse.
	logic ctl_wr; // Write to the transfer control register.
	logic [31:0] step; // Pointer step of the item in flight.

	// Control write decode.
	assign ctl_wr = reg_i.wr && (reg_i.addr == OFS_TRANSFER_CONTROL);

	// Pointer step follows the size latched with the request.
	always_comb
	begin
		unique case (mem_reg.size)
			SIZE_BYTE: step = STEP_BYTE;
			SIZE_HALF: step = STEP_HALF;
			default: step = STEP_WORD;
		endcase
	end

	// ****************************************************************
	// Enable logic
	// ****************************************************************
	// Computes the request enables from control writes.
	always_comb
	begin
		recv_on_next = recv_on_reg;
		xmit_on_next = xmit_on_reg;
		if (ctl_wr && HALF_DUPLEX)
		begin
			// Half duplex keeps one direction at most.
			if (reg_i.wdata[BIT_RECV_REQUEST_OFF] || reg_i.wdata[BIT_XMIT_REQUEST_OFF])
			begin
				recv_on_next = 1'b0;
				xmit_on_next = 1'b0;
			end
			else if (reg_i.wdata[BIT_RECV_REQUEST_ON])
			begin
				recv_on_next = 1'b1;
				xmit_on_next = 1'b0;
			end
			else if (reg_i.wdata[BIT_XMIT_REQUEST_ON] && !recv_on_reg)
				xmit_on_next = 1'b1;
		end
		else if (ctl_wr)
		begin
			// Full duplex directions are independent; disable wins.
			if (reg_i.wdata[BIT_RECV_REQUEST_OFF])
				recv_on_next = 1'b0;
			else if (reg_i.wdata[BIT_RECV_REQUEST_ON])
				recv_on_next = 1'b1;
			if (reg_i.wdata[BIT_XMIT_REQUEST_OFF])
				xmit_on_next = 1'b0;
			else if (reg_i.wdata[BIT_XMIT_REQUEST_ON])
				xmit_on_next = 1'b1;
		end
	end

	// ****************************************************************
	// Channel state and sequencer
	// ****************************************************************
	// Computes reloads, item completion, register writes and sequencing.
	always_comb
	begin
		ch_next = ch_reg;
		state_next = state_reg;
		mem_next = mem_reg;
		xdata_next = xdata_reg;
		taken_next = 1'b0;
		load_next = 1'b0;
		// An empty current buffer takes over a waiting following buffer.
		for (int i = 0; i < 2; i++)
		begin
			if ((ch_reg[i].items == COUNT_ZERO) && (ch_reg[i].fitems != COUNT_ZERO))
			begin
				ch_next[i].addr = ch_reg[i].faddr;
				ch_next[i].items = ch_reg[i].fitems;
				ch_next[i].faddr = ADDR_RESET;
				ch_next[i].fitems = COUNT_ZERO;
			end
		end
		unique case (state_reg)
			PDU_IDLE:
			begin
				// Receive has priority when both sides are ready.
				if (recv_on_reg && recv_ready_i && (ch_reg[0].items != COUNT_ZERO))
				begin
					state_next = PDU_RECV;
					mem_next = '{write: 1'b1, size: item_size_i, addr: ch_reg[0].addr, wdata: recv_holding_reg_i};
					taken_next = 1'b1;
				end
				else if (xmit_on_reg && xmit_ready_i && (ch_reg[XI].items != COUNT_ZERO))
				begin
					state_next = PDU_XMIT;
					mem_next = '{write: 1'b0, size: item_size_i, addr: ch_reg[XI].addr, wdata: ADDR_RESET};
				end
			end
			PDU_RECV:
			begin
				// The item is in memory once the bus acknowledges.
				if (mem_ack_i)
				begin
					state_next = PDU_IDLE;
					ch_next[0].addr = ch_reg[0].addr + step;
					if (ch_reg[0].items != COUNT_ZERO)
						ch_next[0].items = ch_reg[0].items - COUNT_ONE;
				end
			end
			PDU_XMIT:
			begin
				// The fetched item goes to the transmit holding register.
				if (mem_ack_i)
				begin
					state_next = PDU_IDLE;
					xdata_next = mem_rdata_i;
					load_next = 1'b1;
					ch_next[XI].addr = ch_reg[XI].addr + step;
					if (ch_reg[XI].items != COUNT_ZERO)
						ch_next[XI].items = ch_reg[XI].items - COUNT_ONE;
				end
			end
			default: state_next = PDU_IDLE;
		endcase
		// Software writes win over the sequencer in the same cycle.
		if (reg_i.wr)
		begin
			unique case (reg_i.addr)
				OFS_RECV_CURRENT_POINTER: ch_next[0].addr = reg_i.wdata;
				OFS_RECV_CURRENT_COUNT: ch_next[0].items = reg_i.wdata[COUNT_W-1:0];
				OFS_XMIT_CURRENT_POINTER: ch_next[XI].addr = reg_i.wdata;
				OFS_XMIT_CURRENT_COUNT: ch_next[XI].items = reg_i.wdata[COUNT_W-1:0];
				OFS_RECV_NEXT_POINTER: ch_next[0].faddr = reg_i.wdata;
				OFS_RECV_NEXT_COUNT: ch_next[0].fitems = reg_i.wdata[COUNT_W-1:0];
				OFS_XMIT_NEXT_POINTER: ch_next[XI].faddr = reg_i.wdata;
				OFS_XMIT_NEXT_COUNT: ch_next[XI].fitems = reg_i.wdata[COUNT_W-1:0];
				default: ;
			endcase
		end
	end

	// ****************************************************************
	// Register read
	// ****************************************************************
	// Selects read data; unmapped and write-only offsets read zero.
	always_comb
	begin
		rdata_next = rdata_reg;
		if (reg_i.rd)
		begin
			rdata_next = '0;
			unique case (reg_i.addr)
				OFS_RECV_CURRENT_POINTER: rdata_next = ch_reg[0].addr;
				OFS_RECV_CURRENT_COUNT: rdata_next[COUNT_W-1:0] = ch_reg[0].items;
				OFS_XMIT_CURRENT_POINTER: rdata_next = ch_reg[XI].addr;
				OFS_XMIT_CURRENT_COUNT: rdata_next[COUNT_W-1:0] = ch_reg[XI].items;
				OFS_RECV_NEXT_POINTER: rdata_next = ch_reg[0].faddr;
				OFS_RECV_NEXT_COUNT: rdata_next[COUNT_W-1:0] = ch_reg[0].fitems;
				OFS_XMIT_NEXT_POINTER: rdata_next = ch_reg[XI].faddr;
				OFS_XMIT_NEXT_COUNT: rdata_next[COUNT_W-1:0] = ch_reg[XI].fitems;
				OFS_TRANSFER_STATE:
				begin
					rdata_next[BIT_RECV_REQUEST_ON] = recv_on_reg;
					rdata_next[BIT_XMIT_REQUEST_ON] = xmit_on_reg;
				end
				default: ;
			endcase
		end
	end

	// ****************************************************************
	// State registers
	// ****************************************************************
	// Registers all state; reset leaves both channels idle and empty.
	always_ff @(posedge ref_clk_i or posedge rst_i)
	begin
		if (rst_i)
		begin
			for (int i = 0; i < 2; i++)
				ch_reg[i] <= '0;
			recv_on_reg <= 1'b0;
			xmit_on_reg <= 1'b0;
			state_reg <= PDU_IDLE;
			mem_reg <= '0;
			rdata_reg <= '0;
			xdata_reg <= '0;
			taken_reg <= 1'b0;
			load_reg <= 1'b0;
		end
		else
		begin
			ch_reg <= ch_next;
			recv_on_reg <= recv_on_next;
			xmit_on_reg <= xmit_on_next;
			state_reg <= state_next;
			mem_reg <= mem_next;
			rdata_reg <= rdata_next;
			xdata_reg <= xdata_next;
			taken_reg <= taken_next;
			load_reg <= load_next;
		end
	end

	// ****************************************************************
	// Outputs
	// ****************************************************************
	assign reg_rdata_o = rdata_reg;
	assign recv_taken_o = taken_reg;
	assign xmit_load_o = load_reg;
	assign xmit_holding_reg_o = xdata_reg;
	assign mem_req_o = (state_reg != PDU_IDLE);
	assign mem_o = mem_reg;
	assign recv_block_done_o = (ch_reg[0].items == COUNT_ZERO);
	assign recv_all_full_o = (ch_reg[0].items == COUNT_ZERO) && (ch_reg[0].fitems == COUNT_ZERO);
	assign xmit_block_done_o = (ch_reg[XI].items == COUNT_ZERO);
	assign xmit_all_empty_o = (ch_reg[XI].items == COUNT_ZERO) && (ch_reg[XI].fitems == COUNT_ZERO);

	// ****************************************************************
	// Assertions
	// ****************************************************************
	default clocking cb @(posedge ref_clk_i); endclocking
	default disable iff (rst_i);

	// A started receive item ends with one step and one count less.
	sequence s_recv_done;
		(state_reg == PDU_RECV) && mem_ack_i && !reg_i.wr;
	endsequence
	property p_recv_step;
		s_recv_done ##0 (ch_reg[0].items != COUNT_ZERO)
		|=> (ch_reg[0].addr == $past(ch_reg[0].addr) + $past(step))
		&& (ch_reg[0].items == $past(ch_reg[0].items) - COUNT_ONE);
	endproperty
	a_recv_step: assert property (p_recv_step) else $error("receive pointer or count did not advance");

	// No receive item starts from an empty current count.
	property p_recv_stop;
		$rose(state_reg == PDU_RECV) |-> ($past(ch_reg[0].items) != COUNT_ZERO) && $past(recv_on_reg);
	endproperty
	a_recv_stop: assert property (p_recv_stop) else $error("receive started while stopped");

	// No transmit item starts from an empty current count.
	property p_xmit_stop;
		$rose(state_reg == PDU_XMIT) |-> ($past(ch_reg[XI].items) != COUNT_ZERO) && $past(xmit_on_reg);
	endproperty
	a_xmit_stop: assert property (p_xmit_stop) else $error("transmit started while stopped");

	// An empty current receive buffer takes over the following one next cycle.
	property p_reload;
		(ch_reg[0].items == COUNT_ZERO) && (ch_reg[0].fitems != COUNT_ZERO) && !reg_i.wr
		|=> (ch_reg[0].items == $past(ch_reg[0].fitems)) && (ch_reg[0].fitems == COUNT_ZERO)
		&& (ch_reg[0].addr == $past(ch_reg[0].faddr));
	endproperty
	a_reload: assert property (p_reload) else $error("following receive buffer not taken over");

	// A receive disable write always leaves receive requests off.
	property p_recv_off;
		ctl_wr && reg_i.wdata[BIT_RECV_REQUEST_OFF] |=> !recv_on_reg;
	endproperty
	a_recv_off: assert property (p_recv_off) else $error("receive disable ignored");

	// A lone transmit enable in full duplex turns transmit on.
	property p_xmit_on;
		!HALF_DUPLEX && ctl_wr && reg_i.wdata[BIT_XMIT_REQUEST_ON] && !reg_i.wdata[BIT_XMIT_REQUEST_OFF]
		|=> xmit_on_reg;
	endproperty
	a_xmit_on: assert property (p_xmit_on) else $error("transmit enable ignored");

	// Half duplex never has both directions enabled.
	property p_half_excl;
		HALF_DUPLEX |-> !(recv_on_reg && xmit_on_reg);
	endproperty
	a_half_excl: assert property (p_half_excl) else $error("both directions enabled");

	// The state register shows the enables one cycle after the read.
	property p_state_read;
		reg_i.rd && (reg_i.addr == OFS_TRANSFER_STATE)
		|=> (reg_rdata_o[BIT_RECV_REQUEST_ON] == $past(recv_on_reg))
		&& (reg_rdata_o[BIT_XMIT_REQUEST_ON] == $past(xmit_on_reg));
	endproperty
	a_state_read: assert property (p_state_read) else $error("transfer state read wrong");

	// The full flag stands exactly while both receive counts are zero.
	property p_full_flag;
		recv_all_full_o == (recv_block_done_o && (ch_reg[0].fitems == COUNT_ZERO));
	endproperty
	a_full_flag: assert property (p_full_flag) else $error("receive full flag wrong");

endmodule

// *** bench/pdu_mem_model.sv ***
// Memory-side model that answers the channel's bus requests after a set delay.
`timescale 1ns/1ns
module pdu_mem_model
	import pdu_pkg::*;
(
	// Clock and reset.
	input wire logic ref_clk_i,
	input wire logic rst_i,
	// Cycles to wait before each acknowledge.
	input wire logic [3:0] lat_i,
	// Bus port facing the channel.
	input wire logic mem_req_i,
	input wire pdu_mem_req_t mem_i,
	output logic mem_ack_o,
	output logic [31:0] mem_rdata_o
);
	// Cycles the current request has waited so far.
	logic [3:0] wait_reg;
	logic [3:0] wait_next;

	// Count while a request waits and restart once it is answered.
	always_comb
	begin
		wait_next = (mem_req_i && !mem_ack_o) ? wait_reg + 4'h1 : 4'h0;
	end

	// Register the wait count.
	always_ff @(posedge ref_clk_i or posedge rst_i)
	begin
		if (rst_i)
		begin
			wait_reg <= 4'h0;
		end
		else
		begin
			wait_reg <= wait_next;
		end
	end

	// One-cycle acknowledge; read data is valid only with it and scrambled otherwise.
	assign mem_ack_o = mem_req_i && (wait_reg >= lat_i);
	assign mem_rdata_o = mem_ack_o ? (mem_i.addr ^ 32'h5a5a_a5a5) : ~(mem_i.addr ^ 32'h5a5a_a5a5);
endmodule

// *** bench/pdu_channel_tb.sv ***
// Self-checking bench for the channel in full and half duplex form.
`timescale 1ns/1ns
module pdu_channel_tb;
	import pdu_pkg::*;
	// ****************************************************************
	// Stimulus and observation signals
	// ****************************************************************
	logic ref_clk_i = 1'b0;
	logic rst_i = 1'b1;
	pdu_reg_cmd_t cmd [2];
	logic [31:0] rdata [2];
	logic recv_ready = 1'b0;
	logic xmit_ready = 1'b0;
	logic [31:0] recv_word = 32'h0000_0000;
	logic [1:0] size = 2'b00;
	logic [3:0] lat = 4'h0;
	logic mem_req, mem_ack, load;
	logic [31:0] mem_rdata, hold;
	pdu_mem_req_t mem;
	wire [3:0] flags;
	wire [3:0] hflags;
	logic taken;
	int n_tk = 0;
	int n_mismatch = 0;
	int comparisons = 0;
	int n_rx = 0;
	int n_tx = 0;
	// Buffer lengths and bases: receive current, receive next, transmit current, transmit next.
	int len [4];
	logic [31:0] base [4];
	logic [11:0] ofs [4] = '{12'h100, 12'h110, 12'h108, 12'h118};
	// Control writes with expected state in full and half duplex.
	logic [11:0] ctl [10] = '{12'h001, 12'h100, 12'h000, 12'h002, 12'h100, 12'h001, 12'h200, 12'h101, 12'h003, 12'h300};
	logic [11:0] efd [10] = '{12'h001, 12'h101, 12'h101, 12'h100, 12'h100, 12'h101, 12'h001, 12'h101, 12'h100, 12'h000};
	logic [11:0] ehd [10] = '{12'h001, 12'h001, 12'h001, 12'h000, 12'h100, 12'h001, 12'h000, 12'h001, 12'h000, 12'h000};

	always #2 ref_clk_i = ~ref_clk_i;

	pdu_channel #(.HALF_DUPLEX(1'b0)) pdu_channel_i (
		.ref_clk_i(ref_clk_i), .rst_i(rst_i), .reg_i(cmd[0]), .reg_rdata_o(rdata[0]),
		.recv_ready_i(recv_ready), .recv_holding_reg_i(recv_word), .recv_taken_o(taken),
		.xmit_ready_i(xmit_ready), .xmit_holding_reg_o(hold), .xmit_load_o(load), .item_size_i(size),
		.recv_block_done_o(flags[0]), .recv_all_full_o(flags[1]), .xmit_block_done_o(flags[2]),
		.xmit_all_empty_o(flags[3]), .mem_req_o(mem_req), .mem_o(mem), .mem_ack_i(mem_ack),
		.mem_rdata_i(mem_rdata));

	// Half duplex copy is only driven through its registers, so its bus is never answered.
	pdu_channel #(.HALF_DUPLEX(1'b1)) pdu_channel_hd_i (
		.ref_clk_i(ref_clk_i), .rst_i(rst_i), .reg_i(cmd[1]), .reg_rdata_o(rdata[1]),
		.recv_ready_i(recv_ready), .recv_holding_reg_i(recv_word), .recv_taken_o(),
		.xmit_ready_i(xmit_ready), .xmit_holding_reg_o(), .xmit_load_o(), .item_size_i(size),
		.recv_block_done_o(hflags[0]), .recv_all_full_o(hflags[1]), .xmit_block_done_o(hflags[2]),
		.xmit_all_empty_o(hflags[3]),
		.mem_req_o(), .mem_o(), .mem_ack_i(1'b0), .mem_rdata_i(32'h0000_0000));

	pdu_mem_model pdu_mem_model_i (.ref_clk_i(ref_clk_i), .rst_i(rst_i), .lat_i(lat), .mem_req_i(mem_req),
		.mem_i(mem), .mem_ack_o(mem_ack), .mem_rdata_o(mem_rdata));

	// ****************************************************************
	// Shared tasks and expectation functions
	// ****************************************************************
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		comparisons++;
		if (got !== exp)
		begin
			n_mismatch++;
			$display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask

	task automatic test_done();
		$display("Mismatches %0d, comparisons %0d", n_mismatch, comparisons);
		if (n_mismatch == 0 && comparisons > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask

	// Write one register in the copies selected by the mask.
	task automatic wr(input logic [1:0] m, input logic [11:0] a, input logic [31:0] d);
		@(negedge ref_clk_i);
		for (int k = 0; k < 2; k++)
			cmd[k] = m[k] ? pdu_reg_cmd_t'{1'b0, 1'b1, a, d} : '0;
		@(negedge ref_clk_i);
		cmd[0] = '0;
		cmd[1] = '0;
	endtask

	// Read one register and compare it the cycle after.
	task automatic rc(input int k, input logic [11:0] a, input logic [31:0] exp);
		@(negedge ref_clk_i);
		cmd[k] = '{1'b1, 1'b0, a, 32'h0000_0000};
		@(negedge ref_clk_i);
		cmd[k] = '0;
		chk(rdata[k], exp);
	endtask

	// Address of item n of a channel, crossing into the following buffer.
	function automatic logic [31:0] exp_addr(input int c, input int n);
		logic [31:0] st;
		st = (size == 2'b00) ? 32'h0000_0001 : (size == 2'b01) ? 32'h0000_0002 : 32'h0000_0004;
		return (n < len[c]) ? base[c] + st * 32'(n) : base[c + 1] + st * 32'(n - len[c]);
	endfunction

	// Check every acknowledged access and every holding register load.
	always @(negedge ref_clk_i)
	begin
		if (!rst_i && mem_req && mem_ack)
			chk({30'h0, mem.size}, {30'h0, size});
		if (taken)
		begin
			n_tk++;
			chk({31'h0, mem_req && mem.write}, 32'h0000_0001);
		end
		if (!rst_i && mem_req && mem_ack && mem.write)
		begin
			chk(mem.addr, exp_addr(0, n_rx));
			chk(mem.wdata, recv_word);
			n_rx++;
		end
		else if (!rst_i && mem_req && mem_ack)
		begin
			chk(mem.addr, exp_addr(2, n_tx));
			n_tx++;
		end
		if (load)
			chk(hold, exp_addr(2, n_tx - 1) ^ 32'h5a5a_a5a5);
	end

	initial
	begin
		#200000;
		n_mismatch++;
		test_done();
	end

	// ****************************************************************
	// Main sequence
	// ****************************************************************
	initial
	begin
		logic [31:0] d, m;
		logic [11:0] a;
		int t;
		cmd[0] = '0;
		cmd[1] = '0;
		void'($urandom(32'hcccf));
		repeat (4) @(posedge ref_clk_i);
		@(negedge ref_clk_i);
		rst_i = 1'b0;
		chk({28'h0, flags}, 32'h0000_000f);
		chk({28'h0, hflags}, 32'h0000_000f);
		for (int i = 0; i < 10; i++)
			for (int k = 0; k < 2; k++)
				rc(k, 12'h100 + 12'(4 * i), 32'h0000_0000);
		// Random words through every read/write register; the half copy is read at its alias.
		for (int i = 0; i < 8; i++)
		begin
			d = $urandom;
			a = 12'h100 + 12'(4 * i);
			m = a[2] ? 32'h0000_ffff : 32'hffff_ffff;
			wr(2'b11, a, d);
			rc(0, a, d & m);
			rc(1, a ^ 12'h008, d & m);
		end
		chk({28'h0, hflags}, 32'h0000_0000);
		wr(2'b01, 12'h124, 32'hffff_ffff);
		rc(0, 12'h124, 32'h0000_0000);
		rc(0, 12'h200, 32'h0000_0000);
		// One row writes both enables to the half copy on purpose; otherwise software keeps them apart.
		for (int i = 0; i < 10; i++)
		begin
			wr(2'b11, 12'h120, {20'h0, ctl[i]});
			rc(0, 12'h124, {20'h0, efd[i]});
			rc(1, 12'h124, {20'h0, ehd[i]});
		end
		// One burst per item size code, both directions, through the following buffer.
		for (int r = 0; r < 4; r++)
		begin
			size = 2'(r);
			lat = 4'($urandom_range(0, 3));
			recv_word = $urandom;
			n_rx = 0;
			n_tx = 0;
			n_tk = 0;
			for (int c = 0; c < 4; c++)
			begin
				base[c] = $urandom;
				len[c] = $urandom_range(1, 3);
				wr(2'b01, ofs[c], base[c]);
				wr(2'b01, ofs[c] + 12'h004, 32'(len[c]));
			end
			chk({28'h0, flags}, 32'h0000_0000);
			wr(2'b01, 12'h120, 32'h0000_0101);
			recv_ready = 1'b1;
			xmit_ready = 1'b1;
			for (t = 0; t < 400 && (n_rx < len[0] + len[1] || n_tx < len[2] + len[3]); t++)
				@(negedge ref_clk_i);
			if (t == 400)
				n_mismatch++;
			repeat (20) @(negedge ref_clk_i);
			chk(32'(n_rx), 32'(len[0] + len[1]));
			chk(32'(n_tx), 32'(len[2] + len[3]));
			chk(32'(n_tk), 32'(len[0] + len[1]));
			if (n_mismatch != 0)
				test_done();
			chk({28'h0, flags}, 32'h0000_000f);
			rc(0, 12'h100, exp_addr(0, n_rx));
			rc(0, 12'h108, exp_addr(2, n_tx));
			for (int c = 0; c < 4; c++)
				rc(0, ofs[c] + 12'h004, 32'h0000_0000);
			rc(0, 12'h110, 32'h0000_0000);
			rc(0, 12'h118, 32'h0000_0000);
			recv_ready = 1'b0;
			xmit_ready = 1'b0;
			wr(2'b01, 12'h120, 32'h0000_0202);
			rc(0, 12'h124, 32'h0000_0000);
		end
		test_done();
	end
endmodule
